/* rtl/aim_pkg.sv */
// Purpose: Shared constants and types of the converter interface mode block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Times are given in their own unit; cycle counts derive from the pclk rate.

package aim_pkg;

	// ============================================================
	// Bus and register map
	localparam int AIM_ADDR_W = 8;
	localparam int AIM_DATA_W = 32;
	localparam logic [AIM_ADDR_W-1:0] AIM_OFF_RESULT = 8'h00;
	localparam logic [AIM_ADDR_W-1:0] AIM_OFF_CTRL = 8'h04;
	localparam logic [AIM_ADDR_W-1:0] AIM_OFF_STATUS = 8'h08;
	localparam int AIM_CTRL_SEND = 0;
	localparam int AIM_ST_MODE_LO = 0;
	localparam int AIM_ST_UNSUP = 2;
	localparam int AIM_ST_SERIAL = 3;
	localparam int AIM_ST_EXT = 4;
	localparam int AIM_ST_POL = 5;
	localparam int AIM_ST_INV = 6;
	localparam int AIM_ST_CODING = 7;
	localparam int AIM_ST_BUSY = 8;
	localparam int AIM_ST_STALE = 9;

	// ============================================================
	// Result and pins
	localparam int AIM_RES_W = 16;
	localparam int AIM_PIN_W = 7;
	localparam int AIM_SH_LO = 4;
	localparam int AIM_SH_HI = 6;
	localparam int AIM_PIN_EXT = 4;
	localparam int AIM_PIN_POL = 5;
	localparam int AIM_PIN_INV = 6;
	localparam logic [AIM_PIN_W-1:0] AIM_OE_PAR = 7'h7F;
	localparam logic [AIM_PIN_W-1:0] AIM_OE_SER = 7'h0F;
	localparam int AIM_CFG_W = 7;
	localparam int AIM_BITCNT_W = 4;
	localparam logic [AIM_BITCNT_W-1:0] AIM_BIT_LAST = 4'hF;

	// ============================================================
	// Timing
	localparam int AIM_CLK_MHZ = 100;
	localparam int AIM_GAP_US = 1000;
	localparam int AIM_GAP_CYCLES = AIM_GAP_US * AIM_CLK_MHZ;
	localparam int AIM_SCLK_HALF_NS = 20;
	localparam int AIM_SCLK_HALF = (AIM_SCLK_HALF_NS * AIM_CLK_MHZ + 999) / 1000;

	// ============================================================
	// Types
	typedef enum logic [1:0] {
		AIM_MODE_NORMAL,
		AIM_MODE_FAST,
		AIM_MODE_LOW_POWER,
		AIM_MODE_UNSUPPORTED
	} aim_mode_e;

	typedef enum logic {
		AIM_LINK_IDLE,
		AIM_LINK_SHIFT
	} aim_link_e;

endpackage : aim_pkg

/* rtl/aim_sync.sv */
// Purpose: Two-flop level synchroniser, one lane per bit.
// Assumes: Each input bit is a level, or a toggle held until acknowledged.
// Notes: Stage one feeds stage two and nothing else.

`timescale 1ns/1ns

module aim_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule : aim_sync

/* rtl/aim_top.sv */
// Purpose: Interface mode logic of a sampling converter: pin straps, result coding, serial port.
// Assumes: Software writes raw results over APB; strap pins are static while a frame runs.
// Notes: The serial clock pin is read back as the link clock in both clock source modes.

`timescale 1ns/1ns

module aim_top #(
	parameter int GAP_CYCLES = aim_pkg::AIM_GAP_CYCLES,
	parameter int SCLK_HALF = aim_pkg::AIM_SCLK_HALF
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [aim_pkg::AIM_ADDR_W-1:0] paddr,
	input wire logic [aim_pkg::AIM_DATA_W-1:0] pwdata,
	output logic [aim_pkg::AIM_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Strap pins
	input wire logic output_coding_select,
	input wire logic fast_mode_select,
	input wire logic low_power_mode_select,
	input wire logic serial_parallel_select,
	// Shared data pins
	input wire logic [aim_pkg::AIM_SH_HI:aim_pkg::AIM_SH_LO] data_pin_in,
	output logic [aim_pkg::AIM_PIN_W-1:0] data_out,
	output logic [aim_pkg::AIM_PIN_W-1:0] data_oe,
	// Serial port
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	output logic frame_sync_out,
	output logic serial_data_out,
	// Status
	output aim_pkg::aim_mode_e conversion_mode
);

	import aim_pkg::*;

	localparam int GAP_W = $clog2(GAP_CYCLES + 1);
	localparam int DIV_W = $clog2(SCLK_HALF + 1);

	// ============================================================
	// Pin synchronisers
	logic [AIM_CFG_W-1:0] pins_s;
	logic coding_s;
	logic fast_s;
	logic lowp_s;
	logic serial_s;
	logic ext_s;
	logic pol_s;
	logic inv_s;

	aim_sync #(.WIDTH(AIM_CFG_W)) u_pin_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({data_pin_in, serial_parallel_select, low_power_mode_select, fast_mode_select, output_coding_select}),
		.q(pins_s)
	);

	assign coding_s = pins_s[0];
	assign fast_s = pins_s[1];
	assign lowp_s = pins_s[2];
	assign serial_s = pins_s[3];
	// Shared pins only count as straps in serial mode
	assign ext_s = serial_s & pins_s[AIM_PIN_EXT];
	assign pol_s = serial_s & pins_s[AIM_PIN_POL];
	assign inv_s = serial_s & pins_s[AIM_PIN_INV];

	// ============================================================
	// APB side state
	logic [AIM_RES_W-1:0] raw_r, raw_nxt;
	logic [AIM_RES_W-1:0] hold_r, hold_nxt;
	logic [AIM_RES_W-1:0] fmt;
	logic [AIM_DATA_W-1:0] prdata_r, prdata_nxt;
	logic [AIM_DATA_W-1:0] status;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [AIM_PIN_W-1:0] dout_r, dout_nxt;
	logic [AIM_PIN_W-1:0] doe_r, doe_nxt;
	logic sclk_r, sclk_nxt;
	logic sclk_oe_r, sclk_oe_nxt;
	logic inv_r, inv_nxt;
	aim_mode_e mode_r, mode_nxt;
	logic busy_r, busy_nxt;
	logic req_r, req_nxt;
	logic ack_seen_r, ack_seen_nxt;
	logic ack_s;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic [GAP_W-1:0] gap_r, gap_nxt;
	logic stale_r, stale_nxt;
	logic setup;
	logic access;
	logic stale_set;

	always_comb begin
		// Result coding
		fmt = raw_r;
		fmt[AIM_RES_W-1] = raw_r[AIM_RES_W-1] ^ ~coding_s;
		// Mode decode
		unique case ({fast_s, lowp_s})
			2'h2: mode_nxt = AIM_MODE_FAST;
			2'h1: mode_nxt = AIM_MODE_LOW_POWER;
			2'h0: mode_nxt = AIM_MODE_NORMAL;
			2'h3: mode_nxt = AIM_MODE_UNSUPPORTED;
		endcase
		status = '0;
		status[AIM_ST_MODE_LO +: 2] = mode_r;
		status[AIM_ST_UNSUP] = (mode_r == AIM_MODE_UNSUPPORTED);
		status[AIM_ST_SERIAL] = serial_s;
		status[AIM_ST_EXT] = ext_s;
		status[AIM_ST_POL] = pol_s;
		status[AIM_ST_INV] = inv_s;
		status[AIM_ST_CODING] = coding_s;
		status[AIM_ST_BUSY] = busy_r;
		status[AIM_ST_STALE] = stale_r;

		setup = psel & ~penable;
		access = psel & penable & pready_r;
		pready_nxt = setup;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		raw_nxt = raw_r;
		hold_nxt = hold_r;
		busy_nxt = busy_r;
		req_nxt = req_r;
		ack_seen_nxt = ack_seen_r;
		stale_nxt = stale_r;

		// Read data and error are fixed at the end of setup
		if (setup) begin
			prdata_nxt = '0;
			pslverr_nxt = 1'b0;
			unique case (paddr)
				AIM_OFF_RESULT: prdata_nxt[AIM_RES_W-1:0] = fmt;
				AIM_OFF_CTRL: prdata_nxt = '0;
				AIM_OFF_STATUS: prdata_nxt = status;
				default: pslverr_nxt = 1'b1;
			endcase
		end

		// Frame handshake return
		if (busy_r && (ack_s != ack_seen_r)) begin
			busy_nxt = 1'b0;
			ack_seen_nxt = ack_s;
		end

		// Conversion gap watch in fastest mode
		if (mode_r == AIM_MODE_FAST) begin
			gap_nxt = (gap_r == GAP_W'(GAP_CYCLES - 1)) ? gap_r : gap_r + 1'b1;
		end else begin
			gap_nxt = '0;
		end
		stale_set = (mode_r == AIM_MODE_FAST) && (gap_r == GAP_W'(GAP_CYCLES - 1));

		if (access && pwrite) begin
			unique case (paddr)
				AIM_OFF_RESULT: begin
					raw_nxt = pwdata[AIM_RES_W-1:0];
					gap_nxt = '0;
				end
				AIM_OFF_CTRL: begin
					// Send ignored while busy or in parallel mode
					if (pwdata[AIM_CTRL_SEND] && serial_s && !busy_r) begin
						hold_nxt = fmt;
						req_nxt = ~req_r;
						busy_nxt = 1'b1;
					end
				end
				AIM_OFF_STATUS: begin
					if (pwdata[AIM_ST_STALE]) begin
						stale_nxt = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// Set beats clear
		if (stale_set) begin
			stale_nxt = 1'b1;
		end

		// Pin roles
		if (serial_s) begin
			dout_nxt = {3'h0, fmt[AIM_SH_LO-1:0]};
			doe_nxt = AIM_OE_SER;
		end else begin
			dout_nxt = fmt[AIM_PIN_W-1:0];
			doe_nxt = AIM_OE_PAR;
		end

		// Internal clock: divider runs only while a frame is pending
		inv_nxt = inv_s;
		sclk_oe_nxt = serial_s & ~ext_s;
		if (busy_r && !ext_s) begin
			if (div_r == DIV_W'(SCLK_HALF - 1)) begin
				div_nxt = '0;
				sclk_nxt = ~sclk_r;
			end else begin
				div_nxt = div_r + 1'b1;
				sclk_nxt = sclk_r;
			end
		end else begin
			div_nxt = '0;
			sclk_nxt = inv_s;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_r <= '0;
			hold_r <= '0;
			prdata_r <= '0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			dout_r <= '0;
			doe_r <= AIM_OE_PAR;
			sclk_r <= 1'b0;
			sclk_oe_r <= 1'b0;
			inv_r <= 1'b0;
			mode_r <= AIM_MODE_NORMAL;
			busy_r <= 1'b0;
			req_r <= 1'b0;
			ack_seen_r <= 1'b0;
			div_r <= '0;
			gap_r <= '0;
			stale_r <= 1'b0;
		end else begin
			raw_r <= raw_nxt;
			hold_r <= hold_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			dout_r <= dout_nxt;
			doe_r <= doe_nxt;
			sclk_r <= sclk_nxt;
			sclk_oe_r <= sclk_oe_nxt;
			inv_r <= inv_nxt;
			mode_r <= mode_nxt;
			busy_r <= busy_nxt;
			req_r <= req_nxt;
			ack_seen_r <= ack_seen_nxt;
			div_r <= div_nxt;
			gap_r <= gap_nxt;
			stale_r <= stale_nxt;
		end
	end

	// ============================================================
	// Link domain
	// Inversion is folded into the clock, so an inversion change mid-frame glitches it
	logic link_clk;
	logic req_l;
	// Polarity is applied after the link flops: the idle level must follow the strap with no link clock
	aim_link_e lstate_r, lstate_nxt;
	logic seen_r, seen_nxt;
	logic [AIM_RES_W-1:0] shift_r, shift_nxt;
	logic [AIM_BITCNT_W-1:0] cnt_r, cnt_nxt;
	logic sdo_r, sdo_nxt;
	logic fs_r, fs_nxt;

	assign link_clk = sclk_in ^ inv_r;

	aim_sync #(.WIDTH(1)) u_link_sync (
		.clk(link_clk),
		.rst_n(presetn),
		.d(req_r),
		.q(req_l)
	);

	aim_sync #(.WIDTH(1)) u_ack_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d(seen_r),
		.q(ack_s)
	);

	always_comb begin
		lstate_nxt = lstate_r;
		seen_nxt = seen_r;
		shift_nxt = shift_r;
		cnt_nxt = cnt_r;
		sdo_nxt = sdo_r;
		fs_nxt = 1'b0;
		unique case (lstate_r)
			AIM_LINK_IDLE: begin
				// Hold word is stable while the request toggle is outstanding
				if (req_l != seen_r) begin
					sdo_nxt = hold_r[AIM_RES_W-1];
					shift_nxt = hold_r << 1;
					cnt_nxt = '0;
					fs_nxt = 1'b1;
					lstate_nxt = AIM_LINK_SHIFT;
				end
			end
			AIM_LINK_SHIFT: begin
				if (cnt_r == AIM_BIT_LAST) begin
					seen_nxt = ~seen_r;
					lstate_nxt = AIM_LINK_IDLE;
				end else begin
					sdo_nxt = shift_r[AIM_RES_W-1];
					shift_nxt = shift_r << 1;
					cnt_nxt = cnt_r + 1'b1;
					fs_nxt = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			lstate_r <= AIM_LINK_IDLE;
			seen_r <= 1'b0;
			shift_r <= '0;
			cnt_r <= '0;
			sdo_r <= 1'b0;
			fs_r <= 1'b0;
		end else begin
			lstate_r <= lstate_nxt;
			seen_r <= seen_nxt;
			shift_r <= shift_nxt;
			cnt_r <= cnt_nxt;
			sdo_r <= sdo_nxt;
			fs_r <= fs_nxt;
		end
	end

	// ============================================================
	// Outputs
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign data_out = dout_r;
	assign data_oe = doe_r;
	assign sclk_out = sclk_r;
	assign sclk_oe = sclk_oe_r;
	assign frame_sync_out = fs_r ^ pol_s;
	assign serial_data_out = sdo_r;
	assign conversion_mode = mode_r;

endmodule : aim_top

/* verification/aim_host.sv */
// Purpose: Host end of the serial port: external clock and receiver.
// Assumes: Arm follows the send write.
// Notes: Samples on the falling link edge, mid bit.

`timescale 1ns/1ns

module aim_host (
	// Control
	input wire logic arm,
	input wire logic ext_mode,
	input wire logic inv,
	input wire logic pol,
	// Serial pins
	input wire logic sclk_pin,
	input wire logic sdo,
	input wire logic fsync,
	output logic ext_clk,
	// Received frame
	output logic [15:0] word,
	output int nbits
);
	wire logic lk = sclk_pin ^ inv;
	initial begin
		ext_clk = 1'b0;
		word = '0;
		nbits = 0;
	end
	// Clock stands still at link-low between frames
	always @(inv) if (!arm) ext_clk = inv;
	always @(posedge arm) begin
		nbits = 0;
		if (ext_mode) begin
			#7;
			repeat (48) #16 ext_clk = ~ext_clk;
		end
	end
	always @(negedge lk) begin
		if (fsync === !pol) begin
			word = {word[14:0], sdo};
			nbits = nbits + 1;
		end
	end
endmodule : aim_host

/* verification/aim_top_bench.sv */
// Purpose: Self-checking bench of the interface mode block.
// Assumes: Gap timer shortened to 50 pclk.
// Notes: Expected words queue up from the coding model.

`timescale 1ns/1ns

module aim_top_bench;
	import aim_pkg::*;
	localparam int GAP = 50;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, arm, ext_clk;
	logic [AIM_ADDR_W-1:0] paddr;
	logic [AIM_DATA_W-1:0] pwdata, prdata, rd;
	logic coding, fast, lowp, ser, sclk_out, sclk_oe, frame_sync_out, serial_data_out;
	logic [AIM_SH_HI:AIM_SH_LO] pins;
	logic [AIM_PIN_W-1:0] data_out, data_oe;
	logic [15:0] word, raw;
	logic [15:0] exp_q[$];
	int nbits, n_errors, n_checks, n, m;
	aim_mode_e mode;
	wire logic sclk_pin = sclk_oe ? sclk_out : ext_clk;

	aim_top #(.GAP_CYCLES(GAP), .SCLK_HALF(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .output_coding_select(coding), .fast_mode_select(fast), .low_power_mode_select(lowp),
		.serial_parallel_select(ser), .data_pin_in(pins), .data_out(data_out), .data_oe(data_oe),
		.sclk_in(sclk_pin), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .frame_sync_out(frame_sync_out),
		.serial_data_out(serial_data_out), .conversion_mode(mode));
	aim_host host_u (.arm(arm), .ext_mode(pins[AIM_PIN_EXT]), .inv(pins[AIM_PIN_INV]), .pol(pins[AIM_PIN_POL]),
		.sclk_pin(sclk_pin), .sdo(serial_data_out), .fsync(frame_sync_out), .ext_clk(ext_clk), .word(word),
		.nbits(nbits));

	// ======================================
	// Model and tasks
	function automatic logic [15:0] fmt(input logic [15:0] r, input logic c);
		return c ? r : r ^ 16'h8000;
	endfunction : fmt
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		chk(pready, 1'b1, "pready timeout");
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic straps(input logic [3:0] s, input logic [2:0] p);
		@(posedge pclk);
		{coding, ser, lowp, fast} <= s;
		pins <= p;
		repeat (6) @(posedge pclk);
	endtask : straps
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// ======================================
	// Clock, watchdog, tests
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#500000;
		n_errors++;
		wrap_up();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, arm, coding, ser, lowp, fast, pins} = '0;
		presetn = 1'b0;
		void'($urandom(32'h4419));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h0C, '0);
		chk({er, rd[30:0]}, 32'h8000_0000, "unmapped");
		$display("test unmapped done");
		for (int i = 0; i < 4; i++) begin
			straps({2'b00, i[1:0]}, 3'h0);
			apb(1'b0, AIM_OFF_STATUS, '0);
			chk(rd[2:0], {i == 3, i[1:0]}, "mode status");
			chk(mode, i[1:0], "mode out");
		end
		$display("test modes done");
		straps(4'b0001, 3'h0);
		apb(1'b1, AIM_OFF_RESULT, 32'h1234);
		repeat (GAP + 5) @(posedge pclk);
		apb(1'b0, AIM_OFF_STATUS, '0);
		chk(rd[AIM_ST_STALE], 1'b1, "stale");
		straps(4'b0000, 3'h0);
		apb(1'b1, AIM_OFF_STATUS, 32'h200);
		repeat (GAP + 5) @(posedge pclk);
		apb(1'b0, AIM_OFF_STATUS, '0);
		chk(rd[AIM_ST_STALE], 1'b0, "stale normal");
		$display("test gap done");
		for (int c = 0; c < 2; c++) begin
			straps({c[0], 3'b000}, 3'h0);
			raw = $urandom;
			apb(1'b1, AIM_OFF_RESULT, {16'h0, raw});
			repeat (4) @(posedge pclk);
			apb(1'b0, AIM_OFF_RESULT, '0);
			chk(rd, {16'h0, fmt(raw, c[0])}, "coding");
			chk(data_out, raw[6:0], "par pins");
			chk(data_oe, AIM_OE_PAR, "par oe");
		end
		$display("test parallel done");
		for (int k = 0; k < 8; k++) begin
			straps({1'($urandom), 3'b100}, k[2:0]);
			apb(1'b0, AIM_OFF_STATUS, '0);
			chk(rd[7:3], {coding, k[2:0], 1'b1}, "ser straps");
			chk(data_oe, AIM_OE_SER, "ser oe");
			chk(sclk_oe, !k[0], "clk source");
			raw = $urandom;
			exp_q.push_back(fmt(raw, coding));
			apb(1'b1, AIM_OFF_RESULT, {16'h0, raw});
			apb(1'b1, AIM_OFF_CTRL, 32'h1);
			arm <= 1'b1;
			@(posedge pclk);
			arm <= 1'b0;
			m = 0;
			do apb(1'b0, AIM_OFF_STATUS, '0); while (rd[AIM_ST_BUSY] !== 1'b0 && ++m < 100);
			chk(rd[AIM_ST_BUSY], 1'b0, "busy timeout");
			chk(word, exp_q.pop_front(), "ser word");
			chk(nbits, 16, "ser bits");
			chk(frame_sync_out, k[1], "sync idle");
			if (!k[0]) chk(sclk_out, k[2], "clk idle");
		end
		$display("test serial done");
		wrap_up();
	end
endmodule : aim_top_bench

/* verification/aim_top_chk.sv */
// Purpose: Port checks of the interface mode block.
// Assumes: Straps held five pclk before a check.
// Notes: Strap latency is three edges.

`timescale 1ns/1ns

module aim_top_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Straps and pins
	input wire logic fast_mode_select,
	input wire logic low_power_mode_select,
	input wire logic serial_parallel_select,
	input wire logic [aim_pkg::AIM_SH_HI:aim_pkg::AIM_SH_LO] data_pin_in,
	input wire logic [aim_pkg::AIM_PIN_W-1:0] data_oe,
	input wire logic sclk_oe,
	input wire aim_pkg::aim_mode_e conversion_mode
);
	import aim_pkg::*;
	wire logic [1:0] fl = {low_power_mode_select, fast_mode_select};
	wire logic sp = serial_parallel_select;
	wire logic ex = data_pin_in[AIM_PIN_EXT];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ======================================
	// Mode decode
	property p_fast;
		(fl == 2'h1)[*5] |-> conversion_mode == AIM_MODE_FAST;
	endproperty
	a_fast: assert property (p_fast) else $error("fast mode wrong");
	property p_lowp;
		(fl == 2'h2)[*5] |-> (conversion_mode == AIM_MODE_LOW_POWER)[*2];
	endproperty
	a_lowp: assert property (p_lowp) else $error("low power mode wrong");
	property p_norm;
		(fl == 2'h0)[*5] |-> conversion_mode == AIM_MODE_NORMAL;
	endproperty
	a_norm: assert property (p_norm) else $error("normal mode wrong");
	property p_unsup;
		(fl == 2'h3)[*6] |-> $stable(conversion_mode) && conversion_mode == AIM_MODE_UNSUPPORTED;
	endproperty
	a_unsup: assert property (p_unsup) else $error("unsupported mode wrong");

	// ======================================
	// Pin roles
	property p_par;
		!sp[*5] |-> data_oe == AIM_OE_PAR;
	endproperty
	a_par: assert property (p_par) else $error("parallel enables wrong");
	property p_ser;
		sp[*5] |-> data_oe == AIM_OE_SER && data_oe[3:0] == 4'hF;
	endproperty
	a_ser: assert property (p_ser) else $error("serial enables wrong");
	property p_int;
		(sp && !ex)[*5] |-> sclk_oe;
	endproperty
	a_int: assert property (p_int) else $error("internal clock not driven");
	property p_ext;
		(sp && ex)[*5] |-> !sclk_oe;
	endproperty
	a_ext: assert property (p_ext) else $error("clock pin driven in ext mode");
	c_ser: cover property (sp[*5] ##1 sclk_oe);
	c_ext: cover property ((sp && ex)[*5]);
	c_uns: cover property (conversion_mode == AIM_MODE_UNSUPPORTED);
endmodule : aim_top_chk

bind aim_top aim_top_chk chk_u (.pclk(pclk), .presetn(presetn), .fast_mode_select(fast_mode_select),
	.low_power_mode_select(low_power_mode_select), .serial_parallel_select(serial_parallel_select),
	.data_pin_in(data_pin_in), .data_oe(data_oe), .sclk_oe(sclk_oe), .conversion_mode(conversion_mode));
